// File: hdl/bia_pkg.sv
// Purpose: Constants and carriers for the board interrupt aggregator
// Assumes: 32-bit little-endian register port, byte lanes enabled per access
// Notes:   Status word keeps counter flags on even bits 16..22 and on every bit 24..27
package bia_pkg;

  localparam logic [11:0] BIA_OFS_CTRL   = 12'h000;
  localparam logic [11:0] BIA_OFS_STATUS = 12'h004;

  localparam int BIA_BIT_ENABLE  = 0;
  localparam int BIA_BIT_PENDING = 1;
  localparam int BIA_BIT_SWRESET = 14;

  localparam int BIA_NUM_DIO = 16;
  localparam int BIA_NUM_CTR = 8;

  localparam logic [15:0] BIA_CTRL_RESET = 16'h0000;

  // Status bit position of counter n (0-based)
  localparam int BIA_CTR_POS [0:7] = '{16, 18, 20, 22, 24, 25, 26, 27};

  // Host register access, one cycle strobe
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bia_req_t;

endpackage

// File: hdl/bia_top.sv
// Purpose: Board interrupt control and pending/clear status register
// Assumes: Event inputs are one-cycle pulses from same-clock channel logic
// Notes:   Software reset pulses soft_reset_out for the rest of the board

// Notes on behaviour
// - Enable bit 0 gates interrupt request
// - Request holds until cleared or disabled
// - Read-only pending bit 1 reflects any pending
// - Pending independent of enable, cleared at source
// - Pending ORs all digital and counter flags
// - Writing bit 14 resets the whole board
// - Unused register bits read as zero
// - Reset clears interrupt register, interrupts disabled
// - Byte, halfword and word accesses accepted
// - Status bits 0-15 are digital channels
// - Counter flags at 16,18,20,22,24-27 only
// - Joined pairs use lower counter bit
// - Counter status reads live pending state
// - Write one clears, set wins, re-sets
// - Disabled channel never sets its flag
// - Counter enable off releases pending flag
module bia_top import bia_pkg::*; #(
  parameter int NUM_DIO = BIA_NUM_DIO
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Register port
  input  wire bia_pkg::bia_req_t    req,
  output logic [31:0]               rdata,
  output logic                      rvalid,
  // Digital channel events and enables
  input  wire logic [NUM_DIO-1:0]   dio_event,
  input  wire logic [NUM_DIO-1:0]   dio_int_en,
  // Counter events, enables and pair joins
  input  wire logic [7:0]           ctr_event,
  input  wire logic [7:0]           ctr_int_en,
  input  wire logic                 join_56,
  input  wire logic                 join_78,
  // Outputs to system and board
  output logic                      irq,
  output logic                      soft_reset_out
);
  import bia_pkg::*;

  logic              enable_reg, enable_next;
  logic              swrst_reg, swrst_next;
  logic [NUM_DIO-1:0] dio_flag_reg, dio_flag_next;
  logic [7:0]        ctr_flag_reg, ctr_flag_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       clr_mask;
  logic [31:0]       status_word;
  logic [7:0]        ctr_ev_eff, ctr_en_eff, ctr_clr;
  logic              any_pending;
  logic              hit_ctrl, hit_status;
  logic              soft_rst;

  assign hit_ctrl   = req.addr[11:2] == BIA_OFS_CTRL[11:2];
  assign hit_status = req.addr[11:2] == BIA_OFS_STATUS[11:2];
  assign soft_rst   = swrst_reg;

  // Clear mask honours byte lanes only
  always_comb begin
    clr_mask = '0;
    for (int b = 0; b < 4; b++) begin
      if (req.wr && hit_status && req.be[b]) begin
        clr_mask[b*8 +: 8] = req.wdata[b*8 +: 8];
      end
    end
  end

  // Joined pairs: odd counter folds onto the lower position
  always_comb begin
    ctr_ev_eff = ctr_event;
    ctr_en_eff = ctr_int_en;
    if (join_56) begin
      ctr_ev_eff[4] = ctr_event[4] | ctr_event[5];
      ctr_ev_eff[5] = 1'b0;
      ctr_en_eff[5] = 1'b0;
    end
    if (join_78) begin
      ctr_ev_eff[6] = ctr_event[6] | ctr_event[7];
      ctr_ev_eff[7] = 1'b0;
      ctr_en_eff[7] = 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ctr
      assign ctr_clr[g] = clr_mask[BIA_CTR_POS[g]] | ~ctr_en_eff[g];
    end
  endgenerate

  always_comb begin
    status_word = '0;
    status_word[NUM_DIO-1:0] = dio_flag_reg;
    for (int c = 0; c < 8; c++) begin
      status_word[BIA_CTR_POS[c]] = ctr_flag_reg[c];
    end
  end

  // Level, not edge: the request stays up until every source clears
  assign any_pending = |status_word;

  always_comb begin
    enable_next   = enable_reg;
    swrst_next    = 1'b0;
    // Set wins over clear; disabled sources never set
    dio_flag_next = (dio_flag_reg & ~clr_mask[NUM_DIO-1:0])
                  | (dio_event & dio_int_en);
    ctr_flag_next = (ctr_flag_reg & ~ctr_clr)
                  | (ctr_ev_eff & ctr_en_eff);
    rdata_next    = '0;
    rvalid_next   = req.rd;
    if (req.wr && hit_ctrl) begin
      if (req.be[0]) begin
        enable_next = req.wdata[BIA_BIT_ENABLE];
      end
      if (req.be[1] && req.wdata[BIA_BIT_SWRESET]) begin
        swrst_next = 1'b1;
      end
    end
    if (req.rd) begin
      if (hit_ctrl) begin
        rdata_next[BIA_BIT_ENABLE]  = enable_reg;
        rdata_next[BIA_BIT_PENDING] = any_pending;
      end else if (hit_status) begin
        rdata_next = status_word;
      end
    end
    if (soft_rst) begin
      // Same values as the asynchronous reset
      enable_next   = BIA_CTRL_RESET[BIA_BIT_ENABLE];
      dio_flag_next = '0;
      ctr_flag_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg   <= 1'b0;
      swrst_reg    <= 1'b0;
      dio_flag_reg <= '0;
      ctr_flag_reg <= '0;
      rdata_reg    <= '0;
      rvalid_reg   <= 1'b0;
    end else begin
      enable_reg   <= enable_next;
      swrst_reg    <= swrst_next;
      dio_flag_reg <= dio_flag_next;
      ctr_flag_reg <= ctr_flag_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  // Combinational so the request drops the cycle the flag clears
  assign irq            = any_pending & enable_reg;
  assign rdata          = rdata_reg;
  assign rvalid         = rvalid_reg;
  assign soft_reset_out = swrst_reg;

  // Interrupt path checks
  chk_irq_gating: assert property (@(posedge clk) disable iff (!rst_n)
    irq == (enable_reg && status_word != 32'h0)) else $error("irq not gated by enable");
  chk_irq_hold: assert property (@(posedge clk) disable iff (!rst_n)
    irq && !soft_rst && !(req.wr && hit_ctrl && req.be[0]) && clr_mask == 32'h0 && (ctr_clr & ctr_flag_reg) == 8'h00
    |=> irq) else $error("irq dropped");
  chk_pend_read: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && hit_ctrl |=> rdata[BIA_BIT_PENDING] == $past(any_pending)) else $error("pending bit wrong");
  chk_pend_enable: assert property (@(posedge clk) disable iff (!rst_n)
    any_pending && !soft_rst && clr_mask == 32'h0 && (ctr_clr & ctr_flag_reg) == 8'h00
    |=> any_pending) else $error("pending lost");
  chk_swrst_path: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && hit_ctrl && req.be[1] && req.wdata[14] |=> soft_reset_out ##1 (!enable_reg && !any_pending))
    else $error("soft reset ineffective");
  chk_unused_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rvalid && !$past(hit_status) |-> rdata[31:2] == 30'h0) else $error("unused bits set");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rvalid |-> rdata == 32'h0) else $error("read data not idle");
  chk_status_mask: assert property (@(posedge clk) disable iff (!rst_n)
    status_word[31:28] == 0 && status_word[17] == 0 && status_word[23] == 0) else $error("reserved status set");
  chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    dio_event[0] && dio_int_en[0] && !soft_rst |=> dio_flag_reg[0]) else $error("set lost");
  chk_no_set_dis: assert property (@(posedge clk) disable iff (!rst_n)
    !dio_flag_reg[0] && !dio_int_en[0] |=> !dio_flag_reg[0]) else $error("disabled flag set");
  chk_ctr_release: assert property (@(posedge clk) disable iff (!rst_n)
    !ctr_int_en[0] |=> !ctr_flag_reg[0]) else $error("counter not released");

  // Bus-side behaviour: enable write, read timing, read contents
  chk_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && hit_ctrl && req.be[0] && !soft_rst |=> enable_reg == $past(req.wdata[BIA_BIT_ENABLE]))
    else $error("enable write lost");
  chk_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(req.wr && hit_ctrl && req.be[0]) && !soft_rst |=> $stable(enable_reg))
    else $error("enable changed without write");
  chk_irq_off: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_reg |-> !irq) else $error("irq while disabled");
  chk_pend_any: assert property (@(posedge clk) disable iff (!rst_n)
    any_pending == (dio_flag_reg != '0 || ctr_flag_reg != 8'h00)) else $error("pending not OR of flags");
  chk_swrst_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset_out && !(req.wr && hit_ctrl && req.be[1] && req.wdata[BIA_BIT_SWRESET]) |=> !soft_reset_out)
    else $error("soft reset pulse too long");
  chk_reset_state: assert property (@(posedge clk)
    !rst_n && !$past(rst_n) |-> !enable_reg && !irq && !soft_reset_out && !rvalid) else $error("reset state wrong");
  chk_read_valid: assert property (@(posedge clk) disable iff (!rst_n)
    rvalid == $past(req.rd)) else $error("read answer timing wrong");
  chk_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && hit_status |=> rdata == $past(status_word)) else $error("status read wrong");

  // Counter and channel flag checks
  chk_join_fold: assert property (@(posedge clk) disable iff (!rst_n)
    join_56 && ctr_event[5] && ctr_int_en[4] && !soft_rst |=> ctr_flag_reg[4] && !ctr_flag_reg[5])
    else $error("joined pair not folded");
  chk_ctr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && hit_status && req.be[3] && req.wdata[BIA_CTR_POS[4]] && !ctr_ev_eff[4] |=> !ctr_flag_reg[4])
    else $error("counter flag not cleared");
  chk_dio_clear: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && hit_status && req.be[1] && req.wdata[15] && !(dio_event[15] && dio_int_en[15]) |=> !dio_flag_reg[15])
    else $error("channel flag not cleared");

endmodule

// File: verification/bia_host.sv
// Purpose: Host model that issues register reads and writes
// Assumes: One request per call, launched 1 ns after the clock rises
// Notes:   Released fields are inverted so stale values never match
module bia_host (
  // Register port
  input  wire logic         clk,
  output bia_pkg::bia_req_t req,
  input  wire logic [31:0]  rdata,
  input  wire logic         rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  import bia_pkg::*;

  initial req = '0;

  // Read data is taken one cycle after the request edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    #1 req = '{wr: w, rd: !w, addr: a, be: b, wdata: d};
    @(posedge clk);
    #1 q = rvalid ? rdata : 32'hXXXX_XXXX;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~b, wdata: ~d};
  endtask
endmodule

// File: verification/bia_top_tb.sv
// Purpose: Self-checking bench for the board interrupt aggregator
// Assumes: Host model owns the register port, bench owns the events
// Notes:   Events are one-cycle pulses unless a level is needed
module bia_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bia_pkg::*;

  logic        clk, rst_n, join_56, join_78, irq, soft_reset_out, rvalid;
  logic [15:0] dio_event, dio_int_en;
  logic [7:0]  ctr_event, ctr_int_en;
  logic [31:0] rdata, q;
  bia_req_t    req;
  int          error_cnt, cmp_count, cyc;

  bia_top dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid), .dio_event(dio_event),
               .dio_int_en(dio_int_en), .ctr_event(ctr_event), .ctr_int_en(ctr_int_en), .join_56(join_56),
               .join_78(join_78), .irq(irq), .soft_reset_out(soft_reset_out));
  bia_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  always #50 clk = ~clk;

  // Hang guard, far above the roughly 80 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    host.xfer(1'b0, a, 4'hF, 32'h0, q);
    chk(n, e, q);
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    host.xfer(1'b1, a, b, d, q);
  endtask

  task automatic ev(input logic [15:0] d, input logic [7:0] c);
    @(posedge clk);
    #1 dio_event = d;
    ctr_event = c;
    @(posedge clk);
    #1 dio_event = '0;
    ctr_event = '0;
  endtask

  task automatic t_dio;
    dio_int_en = 16'hFFF7;
    ev(16'h8009, 8'h00);
    rd(BIA_OFS_STATUS, 32'h0000_8001, "status");
    rd(BIA_OFS_CTRL, 32'h2, "ctrl");
    chk("irq", 32'h0, {31'h0, irq});
    wr(BIA_OFS_CTRL, 4'h1, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(BIA_OFS_STATUS, 4'hF, 32'h0);
    rd(BIA_OFS_STATUS, 32'h0000_8001, "status");
    wr(BIA_OFS_STATUS, 4'h1, 32'hFFFF_FFFF);
    rd(BIA_OFS_STATUS, 32'h0000_8000, "status");
    chk("irq", 32'h1, {31'h0, irq});
    wr(BIA_OFS_CTRL, 4'h1, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    rd(BIA_OFS_CTRL, 32'h2, "ctrl");
    wr(BIA_OFS_STATUS, 4'h2, 32'h0000_8000);
    rd(BIA_OFS_CTRL, 32'h0, "ctrl");
    dio_event = 16'h0010;
    wr(BIA_OFS_STATUS, 4'h1, 32'h10);
    rd(BIA_OFS_STATUS, 32'h10, "status");
    dio_event = '0;
    wr(BIA_OFS_STATUS, 4'h1, 32'h10);
  endtask

  task automatic t_ctr;
    ctr_int_en = 8'hFF;
    ev(16'h0, 8'hFF);
    rd(BIA_OFS_STATUS, 32'h0F55_0000, "status");
    ctr_int_en = 8'h00;
    rd(BIA_OFS_STATUS, 32'h0, "status");
    ctr_int_en = 8'hFF;
    join_56 = 1'b1;
    join_78 = 1'b1;
    ev(16'h0, 8'hA0);
    rd(BIA_OFS_STATUS, 32'h0500_0000, "status");
    wr(BIA_OFS_STATUS, 4'h8, 32'h0500_0000);
    rd(BIA_OFS_STATUS, 32'h0, "status");
    wr(BIA_OFS_CTRL, 4'hF, 32'hFFFF_BFFF);
    rd(BIA_OFS_CTRL, 32'h1, "ctrl");
    rd(12'h100, 32'h0, "unmapped");
  endtask

  task automatic t_swr;
    ev(16'h0001, 8'h00);
    chk("irq", 32'h1, {31'h0, irq});
    wr(BIA_OFS_CTRL, 4'h2, 32'h4000);
    chk("soft_reset", 32'h1, {31'h0, soft_reset_out});
    @(posedge clk);
    #1 chk("soft_reset", 32'h0, {31'h0, soft_reset_out});
    rd(BIA_OFS_CTRL, 32'h0, "ctrl");
    rd(BIA_OFS_STATUS, 32'h0, "status");
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {clk, rst_n, join_56, join_78} = '0;
    {dio_event, dio_int_en, ctr_event, ctr_int_en} = '0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(BIA_OFS_CTRL, 32'h0, "ctrl");
    t_dio();
    t_ctr();
    t_swr();
    tally_and_finish();
  end
endmodule
